//--- hw/sst_pkg.sv
// Constants for the synchronous slave serial transmitter
package sst_pkg;
    // Register byte offsets (AXI4-Lite word aligned)
    localparam logic [5:0] OFF_TX_CTRL   = 6'h00;
    localparam logic [5:0] OFF_RX_CTRL   = 6'h04;
    localparam logic [5:0] OFF_BAUD_CTRL = 6'h08;
    localparam logic [5:0] OFF_DIV_LO    = 6'h0C;
    localparam logic [5:0] OFF_DIV_HI    = 6'h10;
    localparam logic [5:0] OFF_TX_DATA   = 6'h14;
    localparam logic [5:0] OFF_CORE_IRQ  = 6'h18;
    localparam logic [5:0] OFF_PERIPHERAL_IRQ_ENABLE_1      = 6'h1C;
    localparam logic [5:0] OFF_PERIPHERAL_IRQ_FLAGS_1      = 6'h20;
    localparam logic [5:0] OFF_PORTC_DIR = 6'h24;
    localparam logic [5:0] OFF_IRQ_STAT  = 6'h28;
    localparam logic [5:0] OFF_IRQ_MASK  = 6'h2C;
    localparam logic [5:0] OFF_SLEEP     = 6'h30;
    // Transmit control/status bit positions
    localparam int TX_CLKSRC = 7;
    localparam int TX_NINTH  = 6;
    localparam int TX_EN     = 5;
    localparam int TX_SYNC   = 4;
    localparam int TX_EMPTY  = 1;
    localparam int TX_9VAL   = 0;
    // Receive control/status bit positions
    localparam int RX_SERIAL_PORT_ENABLE   = 7;
    localparam int RX_SINGLE_RECEIVE_ENABLE   = 5;
    localparam int RX_CONTINUOUS_RECEIVE_ENABLE   = 4;
    // Interrupt bit positions
    localparam int IE_TX     = 4;
    localparam int IC_GIE    = 7;
    localparam int IC_PERIPHERAL_IRQ_ENABLE   = 6;
    // Baud control implemented bits (bits 5 and 2 read zero)
    localparam logic [7:0] BAUD_MASK  = 8'hDB;
    localparam logic [7:0] TRIS_RESET = 8'hFF;
    // Event status bits
    localparam int EV_BUF_FREE = 0;
    localparam int EV_DONE     = 1;
    localparam int EV_WAKE     = 2;
    localparam int EV_W        = 3;
    localparam logic [1:0] RESP_OKAY   = 2'b00;
    localparam logic [1:0] RESP_SLVERR = 2'b10;
    localparam logic [3:0] BITS_8 = 4'h8;
    localparam logic [3:0] BITS_9 = 4'h9;
    typedef enum logic [1:0] {
        SH_IDLE = 2'b00,
        SH_LOAD = 2'b01,
        SH_BUSY = 2'b10
    } sst_shift_t;
endpackage

//--- hw/sst_top.sv
// Synchronous slave serial transmitter with AXI4-Lite registers
//
// Behaviour
// - Clocked half-duplex mode runs while the sync bit is one.
// - Clock source bit zero makes the port a slave on outside clock.
// - Both receive enables zero selects transmit, either selects receive.
// - Whole port works only while the serial port enable is set.
// - Buffering, flagging, shifting as master transmit, apart from sleep.
// - With two words queued, the first moves to the shifter at once.
// - The second word waits in the holding register meanwhile.
// - Buffer free flag stays clear while the holding register is full.
// - After the first word, the second moves over, then flag sets.
// - Flag set in sleep with peripheral and transmit enables wakes core.
// - Global enable also set on wake makes the core take the interrupt.
// - Transmit enable must be set before data is loaded.
// - Writing the low byte starts transmission, ninth bit from its field.
// - Unimplemented baud control bits read back as zero.
//
// Design decisions made here: the address map and the AXI4-Lite interface to the registers.
`timescale 1ns/1ns
module sst_top #(
    parameter int ADDR_W = 6                    // Address width
) (
    input  wire logic              aclk,          // System clock
    input  wire logic              aresetn,       // Sync reset, low
    input  wire logic [ADDR_W-1:0] s_axi_awaddr,  // Write address
    input  wire logic              s_axi_awvalid, // Write addr valid
    output logic                   s_axi_awready, // Write addr ready
    input  wire logic [31:0]       s_axi_wdata,   // Write data
    input  wire logic [3:0]        s_axi_wstrb,   // Write strobes
    input  wire logic              s_axi_wvalid,  // Write data valid
    output logic                   s_axi_wready,  // Write data ready
    output logic [1:0]             s_axi_bresp,   // Write response
    output logic                   s_axi_bvalid,  // Write resp valid
    input  wire logic              s_axi_bready,  // Write resp ready
    input  wire logic [ADDR_W-1:0] s_axi_araddr,  // Read address
    input  wire logic              s_axi_arvalid, // Read addr valid
    output logic                   s_axi_arready, // Read addr ready
    output logic [31:0]            s_axi_rdata,   // Read data
    output logic [1:0]             s_axi_rresp,   // Read response
    output logic                   s_axi_rvalid,  // Read data valid
    input  wire logic              s_axi_rready,  // Read data ready
    input  wire logic              link_clk,      // Shift clock from master
    output logic                   data_out,      // Serial data out
    output logic                   data_oe,       // Data pin drive enable
    output logic                   irq,           // Interrupt level
    output logic                   wake,          // Wake request to core
    output logic                   core_vector    // Take interrupt vector
);
    // Register state
    logic [7:0] tx_ctrl_r, tx_ctrl_nxt;
    logic [7:0] rx_ctrl_r, rx_ctrl_nxt;
    logic [7:0] baud_r, baud_nxt;
    logic [7:0] div_lo_r, div_lo_nxt;
    logic [7:0] div_hi_r, div_hi_nxt;
    logic [7:0] hold_r, hold_nxt;
    logic       hold_9_r, hold_9_nxt;
    logic       hold_full_r, hold_full_nxt;
    logic [7:0] core_ic_r, core_ic_nxt;
    logic [7:0] peripheral_irq_enable_1_r, peripheral_irq_enable_1_nxt;
    logic [7:0] tris_r, tris_nxt;
    localparam int EV_W_L = sst_pkg::EV_W;
    logic [EV_W_L-1:0] stat_r, stat_nxt;
    logic [EV_W_L-1:0] mask_r, mask_nxt;
    logic       sleep_r, sleep_nxt;
    // Bus state
    logic              aw_got_r, aw_got_nxt;
    logic              w_got_r, w_got_nxt;
    logic [ADDR_W-1:0] aw_addr_r, aw_addr_nxt;
    logic [31:0]       w_data_r, w_data_nxt;
    logic [3:0]        w_strb_r, w_strb_nxt;
    logic              bvalid_r, bvalid_nxt;
    logic [1:0]        bresp_r, bresp_nxt;
    logic              rvalid_r, rvalid_nxt;
    logic [31:0]       rdata_r, rdata_nxt;
    logic [1:0]        rresp_r, rresp_nxt;
    // Shifter state
    sst_pkg::sst_shift_t sh_st_r, sh_st_nxt;
    logic [8:0] tsr_r, tsr_nxt;
    logic [3:0] bits_r, bits_nxt;
    logic       dout_r, dout_nxt;
    logic       oe_r, oe_nxt;
    logic [2:0] lk_sync_r;
    logic       irq_r, wake_r, vec_r;

    // Known register offsets
    function automatic logic addr_known(input logic [ADDR_W-1:0] a);
        case (a[5:0])
            sst_pkg::OFF_TX_CTRL, sst_pkg::OFF_RX_CTRL,
            sst_pkg::OFF_BAUD_CTRL, sst_pkg::OFF_DIV_LO,
            sst_pkg::OFF_DIV_HI, sst_pkg::OFF_TX_DATA,
            sst_pkg::OFF_CORE_IRQ, sst_pkg::OFF_PERIPHERAL_IRQ_ENABLE_1,
            sst_pkg::OFF_PERIPHERAL_IRQ_FLAGS_1, sst_pkg::OFF_PORTC_DIR,
            sst_pkg::OFF_IRQ_STAT, sst_pkg::OFF_IRQ_MASK,
            sst_pkg::OFF_SLEEP: addr_known = 1'b1;
            default: addr_known = 1'b0;
        endcase
    endfunction

    // Mode decode
    logic port_on, slave_tx, tx_active, buf_free, clk_edge;
    assign port_on   = rx_ctrl_r[sst_pkg::RX_SERIAL_PORT_ENABLE];
    assign slave_tx  = tx_ctrl_r[sst_pkg::TX_SYNC]
                     & ~tx_ctrl_r[sst_pkg::TX_CLKSRC]
                     & ~rx_ctrl_r[sst_pkg::RX_SINGLE_RECEIVE_ENABLE]
                     & ~rx_ctrl_r[sst_pkg::RX_CONTINUOUS_RECEIVE_ENABLE];
    assign tx_active = port_on & slave_tx & tx_ctrl_r[sst_pkg::TX_EN];
    assign buf_free  = ~hold_full_r;
    // Falling edge of agreed link clock; data changes on it
    assign clk_edge  = lk_sync_r[2] & ~lk_sync_r[1];

    // Link clock synchroniser
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            lk_sync_r <= 3'b000;
        end else begin
            lk_sync_r <= {lk_sync_r[1:0], link_clk};
        end
    end

    // Bus handshake and register writes
    logic do_wr, do_rd, wr_hold;
    logic [7:0] wb;
    logic [EV_W_L-1:0] ev;
    always_comb begin
        aw_got_nxt  = aw_got_r;
        w_got_nxt   = w_got_r;
        aw_addr_nxt = aw_addr_r;
        w_data_nxt  = w_data_r;
        w_strb_nxt  = w_strb_r;
        bvalid_nxt  = bvalid_r;
        bresp_nxt   = bresp_r;
        rvalid_nxt  = rvalid_r;
        rdata_nxt   = rdata_r;
        rresp_nxt   = rresp_r;
        tx_ctrl_nxt = tx_ctrl_r;
        rx_ctrl_nxt = rx_ctrl_r;
        baud_nxt    = baud_r;
        div_lo_nxt  = div_lo_r;
        div_hi_nxt  = div_hi_r;
        core_ic_nxt = core_ic_r;
        peripheral_irq_enable_1_nxt    = peripheral_irq_enable_1_r;
        tris_nxt    = tris_r;
        mask_nxt    = mask_r;
        sleep_nxt   = sleep_r;
        wr_hold     = 1'b0;
        wb          = w_data_r[7:0];
        if (s_axi_awvalid && !aw_got_r && !bvalid_r) begin
            aw_got_nxt  = 1'b1;
            aw_addr_nxt = s_axi_awaddr;
        end
        if (s_axi_wvalid && !w_got_r && !bvalid_r) begin
            w_got_nxt  = 1'b1;
            w_data_nxt = s_axi_wdata;
            w_strb_nxt = s_axi_wstrb;
        end
        do_wr = aw_got_r & w_got_r & ~bvalid_r;
        if (do_wr) begin
            aw_got_nxt = 1'b0;
            w_got_nxt  = 1'b0;
            bvalid_nxt = 1'b1;
            bresp_nxt  = addr_known(aw_addr_r) ? sst_pkg::RESP_OKAY
                                               : sst_pkg::RESP_SLVERR;
            if (w_strb_r[0]) begin
                case (aw_addr_r[5:0])
                    sst_pkg::OFF_TX_CTRL: begin
                        // Empty bit is status only
                        tx_ctrl_nxt = wb;
                        tx_ctrl_nxt[sst_pkg::TX_EMPTY] = 1'b0;
                    end
                    sst_pkg::OFF_RX_CTRL:   rx_ctrl_nxt = wb;
                    sst_pkg::OFF_BAUD_CTRL:
                        baud_nxt = wb & sst_pkg::BAUD_MASK;
                    sst_pkg::OFF_DIV_LO:    div_lo_nxt  = wb;
                    sst_pkg::OFF_DIV_HI:    div_hi_nxt  = wb;
                    sst_pkg::OFF_CORE_IRQ:  core_ic_nxt = wb;
                    sst_pkg::OFF_PERIPHERAL_IRQ_ENABLE_1:      peripheral_irq_enable_1_nxt    = wb;
                    sst_pkg::OFF_PORTC_DIR: tris_nxt    = wb;
                    sst_pkg::OFF_IRQ_MASK:  mask_nxt    = wb[EV_W_L-1:0];
                    sst_pkg::OFF_SLEEP:     sleep_nxt   = wb[0];
                    // Loads ignored unless transmitter enabled
                    sst_pkg::OFF_TX_DATA:   wr_hold = tx_active;
                    default: ;
                endcase
            end
        end
        if (bvalid_r && s_axi_bready) begin
            bvalid_nxt = 1'b0;
        end
        // Wake event ends sleep
        if (ev[sst_pkg::EV_WAKE]) begin
            sleep_nxt = 1'b0;
        end
        do_rd = s_axi_arvalid & ~rvalid_r;
        if (do_rd) begin
            rvalid_nxt = 1'b1;
            rresp_nxt  = addr_known(s_axi_araddr) ? sst_pkg::RESP_OKAY
                                                  : sst_pkg::RESP_SLVERR;
            rdata_nxt  = 32'h0000_0000;
            case (s_axi_araddr[5:0])
                sst_pkg::OFF_TX_CTRL: begin
                    rdata_nxt[7:0] = tx_ctrl_r;
                    rdata_nxt[sst_pkg::TX_EMPTY] =
                        (sh_st_r == sst_pkg::SH_IDLE);
                end
                sst_pkg::OFF_RX_CTRL:   rdata_nxt[7:0] = rx_ctrl_r;
                sst_pkg::OFF_BAUD_CTRL: rdata_nxt[7:0] = baud_r;
                sst_pkg::OFF_DIV_LO:    rdata_nxt[7:0] = div_lo_r;
                sst_pkg::OFF_DIV_HI:    rdata_nxt[7:0] = div_hi_r;
                sst_pkg::OFF_TX_DATA:   rdata_nxt[7:0] = hold_r;
                sst_pkg::OFF_CORE_IRQ:  rdata_nxt[7:0] = core_ic_r;
                sst_pkg::OFF_PERIPHERAL_IRQ_ENABLE_1:      rdata_nxt[7:0] = peripheral_irq_enable_1_r;
                sst_pkg::OFF_PERIPHERAL_IRQ_FLAGS_1:
                    rdata_nxt[sst_pkg::IE_TX] = buf_free;
                sst_pkg::OFF_PORTC_DIR: rdata_nxt[7:0] = tris_r;
                sst_pkg::OFF_IRQ_STAT:  rdata_nxt[EV_W_L-1:0] = stat_r;
                sst_pkg::OFF_IRQ_MASK:  rdata_nxt[EV_W_L-1:0] = mask_r;
                sst_pkg::OFF_SLEEP:     rdata_nxt[0] = sleep_r;
                default: ;
            endcase
        end
        if (rvalid_r && s_axi_rready) begin
            rvalid_nxt = 1'b0;
        end
    end

    // Holding register and shifter
    logic tsr_load, word_done;
    always_comb begin
        hold_nxt      = hold_r;
        hold_9_nxt    = hold_9_r;
        hold_full_nxt = hold_full_r;
        sh_st_nxt     = sh_st_r;
        tsr_nxt       = tsr_r;
        bits_nxt      = bits_r;
        dout_nxt      = dout_r;
        oe_nxt        = tx_active;
        tsr_load      = 1'b0;
        word_done     = 1'b0;
        if (wr_hold) begin
            // Ninth bit latched with the low byte
            hold_nxt      = wb;
            hold_9_nxt    = tx_ctrl_r[sst_pkg::TX_9VAL];
            hold_full_nxt = 1'b1;
        end
        case (sh_st_r)
            sst_pkg::SH_IDLE: begin
                // Move at once when idle, even before sleep
                if (hold_full_r && tx_active) begin
                    sh_st_nxt = sst_pkg::SH_LOAD;
                end
            end
            sst_pkg::SH_LOAD: begin
                tsr_load  = 1'b1;
                tsr_nxt   = {hold_9_r, hold_r};
                bits_nxt  = tx_ctrl_r[sst_pkg::TX_NINTH]
                          ? sst_pkg::BITS_9 : sst_pkg::BITS_8;
                hold_full_nxt = wr_hold;
                sh_st_nxt = sst_pkg::SH_BUSY;
            end
            sst_pkg::SH_BUSY: begin
                if (!tx_active) begin
                    sh_st_nxt = sst_pkg::SH_IDLE;
                end else if (clk_edge) begin
                    dout_nxt = tsr_r[0];
                    tsr_nxt  = {1'b0, tsr_r[8:1]};
                    bits_nxt = bits_r - 4'h1;
                    if (bits_r == 4'h1) begin
                        word_done = 1'b1;
                        // Queued second word follows directly
                        sh_st_nxt = hold_full_r ? sst_pkg::SH_LOAD
                                                : sst_pkg::SH_IDLE;
                    end
                end
            end
            default: sh_st_nxt = sst_pkg::SH_IDLE;
        endcase
    end

    // Events, sticky status and wake
    logic buf_free_d_r;
    logic pie_gate;
    assign pie_gate = core_ic_r[sst_pkg::IC_PERIPHERAL_IRQ_ENABLE]
                    & peripheral_irq_enable_1_r[sst_pkg::IE_TX];
    always_comb begin
        ev = '0;
        ev[sst_pkg::EV_BUF_FREE] = buf_free & ~buf_free_d_r;
        ev[sst_pkg::EV_DONE]     = word_done;
        ev[sst_pkg::EV_WAKE]     = sleep_r & buf_free & pie_gate;
        stat_nxt = stat_r;
        if (do_wr && w_strb_r[0]
            && aw_addr_r[5:0] == sst_pkg::OFF_IRQ_STAT) begin
            stat_nxt = stat_r & ~w_data_r[EV_W_L-1:0];
        end
        stat_nxt = stat_nxt | ev;
    end

    // Register update
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            tx_ctrl_r <= 8'h00;
            rx_ctrl_r <= 8'h00;
            baud_r <= 8'h00;
            div_lo_r <= 8'h00;
            div_hi_r <= 8'h00;
            hold_r <= 8'h00;
            hold_9_r <= 1'b0;
            hold_full_r <= 1'b0;
            core_ic_r <= 8'h00;
            peripheral_irq_enable_1_r <= 8'h00;
            tris_r    <= sst_pkg::TRIS_RESET;
            stat_r <= '0;
            mask_r <= '0;
            sleep_r <= 1'b0;
            aw_got_r <= 1'b0;
            w_got_r <= 1'b0;
            aw_addr_r <= '0;
            w_data_r <= 32'h0000_0000;
            w_strb_r <= 4'h0;
            bvalid_r <= 1'b0;
            bresp_r <= 2'b00;
            rvalid_r <= 1'b0;
            rdata_r <= 32'h0000_0000;
            rresp_r   <= 2'b00;
            sh_st_r   <= sst_pkg::SH_IDLE;
            tsr_r <= 9'h000;
            bits_r <= 4'h0;
            dout_r <= 1'b0;
            oe_r <= 1'b0;
            buf_free_d_r <= 1'b1;
            irq_r <= 1'b0;
            wake_r <= 1'b0;
            vec_r <= 1'b0;
        end else begin
            tx_ctrl_r <= tx_ctrl_nxt;
            rx_ctrl_r <= rx_ctrl_nxt;
            baud_r <= baud_nxt;
            div_lo_r <= div_lo_nxt;
            div_hi_r <= div_hi_nxt;
            hold_r <= hold_nxt;
            hold_9_r <= hold_9_nxt;
            hold_full_r <= hold_full_nxt;
            core_ic_r <= core_ic_nxt;
            peripheral_irq_enable_1_r <= peripheral_irq_enable_1_nxt;
            tris_r <= tris_nxt;
            stat_r <= stat_nxt;
            mask_r <= mask_nxt;
            sleep_r <= sleep_nxt;
            aw_got_r <= aw_got_nxt;
            w_got_r <= w_got_nxt;
            aw_addr_r <= aw_addr_nxt;
            w_data_r <= w_data_nxt;
            w_strb_r <= w_strb_nxt;
            bvalid_r <= bvalid_nxt;
            bresp_r <= bresp_nxt;
            rvalid_r <= rvalid_nxt;
            rdata_r <= rdata_nxt;
            rresp_r <= rresp_nxt;
            sh_st_r <= sh_st_nxt;
            tsr_r <= tsr_nxt;
            bits_r <= bits_nxt;
            dout_r <= dout_nxt;
            oe_r <= oe_nxt;
            buf_free_d_r <= buf_free;
            irq_r     <= |(stat_nxt & mask_r);
            wake_r    <= ev[sst_pkg::EV_WAKE];
            vec_r     <= ev[sst_pkg::EV_WAKE]
                       & core_ic_r[sst_pkg::IC_GIE];
        end
    end

    // Outputs from flip-flops, the ready signals through gates on them
    assign s_axi_awready = ~aw_got_r & ~bvalid_r;
    assign s_axi_wready  = ~w_got_r & ~bvalid_r;
    assign s_axi_bvalid  = bvalid_r;
    assign s_axi_bresp   = bresp_r;
    assign s_axi_arready = ~rvalid_r;
    assign s_axi_rvalid  = rvalid_r;
    assign s_axi_rdata   = rdata_r;
    assign s_axi_rresp   = rresp_r;
    assign data_out      = dout_r;
    assign data_oe       = oe_r;
    assign irq           = irq_r;
    assign wake          = wake_r;
    assign core_vector   = vec_r;
endmodule

//--- verif/sst_link_master.sv
// Model of the outside master that supplies the shift clock
`timescale 1ns/1ns
module sst_link_master (
    output logic      link_clk, // Shift clock, idles high
    input  wire logic data_out, // Serial data from the port
    input  wire logic data_oe   // Port drives the data line
);
    // Clock stands still high between frames
    initial link_clk = 1'b1;
    // One frame, LSB first, sampled late in each high phase
    task automatic shift(input int n, input int half, output logic [8:0] w);
        w = '0;
        for (int i = 0; i < n; i++) begin
            link_clk <= 1'b0;
            #(half);
            link_clk <= 1'b1;
            #(half - 20);
            w[i] = data_oe ? data_out : 1'bx;
            #20;
        end
    endtask
endmodule

//--- verif/sst_top_monitor.sv
// Port checker for the serial transmitter top
`timescale 1ns/1ns
module sst_top_monitor (
    input wire logic        aclk,          // System clock
    input wire logic        aresetn,       // Sync reset, low
    input wire logic        s_axi_awvalid, // Write addr valid
    input wire logic        s_axi_awready, // Write addr ready
    input wire logic        s_axi_wvalid,  // Write data valid
    input wire logic        s_axi_wready,  // Write data ready
    input wire logic        s_axi_bvalid,  // Write resp valid
    input wire logic        s_axi_bready,  // Write resp ready
    input wire logic        s_axi_arvalid, // Read addr valid
    input wire logic        s_axi_arready, // Read addr ready
    input wire logic        s_axi_rvalid,  // Read data valid
    input wire logic        s_axi_rready,  // Read data ready
    input wire logic [31:0] s_axi_rdata,   // Read data
    input wire logic [1:0]  s_axi_rresp,   // Read response
    input wire logic        wake,          // Wake request
    input wire logic        core_vector    // Vector request
);
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    // Both write channels taken on one edge
    sequence s_wr_both;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
    endsequence
    // Read address taken
    sequence s_rd_took;
        s_axi_arvalid && s_axi_arready;
    endsequence
    property p_b_answer;
        s_wr_both |-> ##2 s_axi_bvalid;
    endproperty
    a_b_answer: assert property (p_b_answer) else $error("bvalid late");
    property p_b_cause;
        $rose(s_axi_bvalid) |-> $past(s_axi_awvalid && s_axi_awready
            || s_axi_wvalid && s_axi_wready, 2);
    endproperty
    a_b_cause: assert property (p_b_cause) else $error("bvalid uncaused");
    property p_b_once;
        s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid;
    endproperty
    a_b_once: assert property (p_b_once) else $error("bvalid repeated");
    property p_r_answer;
        s_rd_took |=> s_axi_rvalid;
    endproperty
    a_r_answer: assert property (p_r_answer) else $error("rvalid late");
    property p_r_cause;
        $rose(s_axi_rvalid) |-> $past(s_axi_arvalid && s_axi_arready);
    endproperty
    a_r_cause: assert property (p_r_cause) else $error("rvalid uncaused");
    property p_r_once;
        s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid;
    endproperty
    a_r_once: assert property (p_r_once) else $error("rvalid repeated");
    property p_err_zero;
        s_axi_rvalid && s_axi_rresp == sst_pkg::RESP_SLVERR
            |-> s_axi_rdata == 32'h0000_0000;
    endproperty
    a_err_zero: assert property (p_err_zero) else $error("error data set");
    property p_vec_wake;
        core_vector |-> wake;
    endproperty
    a_vec_wake: assert property (p_vec_wake)
        else $error("vector no wake");
endmodule

bind sst_top sst_top_monitor mon_u (
    .aclk(aclk), .aresetn(aresetn), .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready), .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp), .wake(wake), .core_vector(core_vector));

//--- verif/sst_top_tb.sv
// Self-checking bench for the serial transmitter top
`timescale 1ns/1ns
module sst_top_tb;
    logic        aclk, aresetn, awvalid, awready, wvalid, wready;
    logic        bvalid, bready, arvalid, arready, rvalid, rready;
    logic        link_clk, data_out, data_oe, irq, wake, core_vector;
    logic [5:0]  awaddr, araddr;
    logic [31:0] wdata, rdata, v;
    logic [3:0]  wstrb;
    logic [1:0]  bresp, rresp, last_resp;
    int          failures, compares, wake_cnt, vec_cnt;
    sst_top dut_u (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
        .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
        .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
        .s_axi_bready(bready), .s_axi_araddr(araddr),
        .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
        .s_axi_rready(rready), .link_clk(link_clk), .data_out(data_out),
        .data_oe(data_oe), .irq(irq), .wake(wake),
        .core_vector(core_vector));
    sst_link_master lm_u (.link_clk(link_clk), .data_out(data_out),
        .data_oe(data_oe));
    // Clock source
    initial begin
        aclk = 1'b0;
        forever #50 aclk = ~aclk;
    end
    // Count cycles with wake and vector requests
    always @(posedge aclk) begin
        if (wake === 1'b1) wake_cnt++;
        if (core_vector === 1'b1) vec_cnt++;
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            failures++;
            $display("wrong value at %0t: got %h want %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [5:0] a, input logic [31:0] d);
        @(posedge aclk);
        awaddr  <= a;
        wdata   <= d;
        awvalid <= 1'b1;
        wvalid  <= 1'b1;
        bready  <= 1'b1;
        do begin
            @(posedge aclk);
            if (awvalid && awready) awvalid <= 1'b0;
            if (wvalid && wready) wvalid <= 1'b0;
        end while (bvalid !== 1'b1);
        bready <= 1'b0;
        last_resp = bresp;
    endtask
    task automatic rdc(input logic [5:0] a, input logic [31:0] m, e);
        @(posedge aclk);
        araddr  <= a;
        arvalid <= 1'b1;
        rready  <= 1'b1;
        do begin
            @(posedge aclk);
            if (arvalid && arready) arvalid <= 1'b0;
        end while (rvalid !== 1'b1);
        rready <= 1'b0;
        v = rdata;
        last_resp = rresp;
        chk(v & m, e);
    endtask
    // Read until a flag shows, bounded
    task automatic poll(input logic [5:0] a, input logic [31:0] m);
        v = '0;
        for (int i = 0; i < 30 && (v & m) !== m; i++) rdc(a, 32'h0, 32'h0);
        chk(v & m, m);
    endtask
    task automatic t_regs();
        rdc(sst_pkg::OFF_TX_CTRL, 32'hFF, 32'h02);
        rdc(sst_pkg::OFF_PORTC_DIR, 32'hFF, {24'h0, sst_pkg::TRIS_RESET});
        wr(sst_pkg::OFF_BAUD_CTRL, 32'hFF);
        rdc(sst_pkg::OFF_BAUD_CTRL, 32'hFF, {24'h0, sst_pkg::BAUD_MASK});
        wr(6'h34, 32'h01);
        chk({30'h0, last_resp}, {30'h0, sst_pkg::RESP_SLVERR});
        rdc(6'h3C, 32'hFFFF_FFFF, 32'h0);
        chk({30'h0, last_resp}, {30'h0, sst_pkg::RESP_SLVERR});
        $display("test regs done");
    endtask
    task automatic t_modes();
        logic [7:0] txv [5] = '{8'h20, 8'hB0, 8'h30, 8'h30, 8'h30};
        logic [7:0] rxv [5] = '{8'h80, 8'h80, 8'hA0, 8'h90, 8'h00};
        for (int i = 0; i < 5; i++) begin
            wr(sst_pkg::OFF_RX_CTRL, {24'h0, rxv[i]});
            wr(sst_pkg::OFF_TX_CTRL, {24'h0, txv[i]});
            wr(sst_pkg::OFF_TX_DATA, 32'h5A);
            repeat (4) @(posedge aclk);
            chk({31'h0, data_oe}, 32'h0);
            rdc(sst_pkg::OFF_TX_CTRL, 32'h02, 32'h02);
        end
        wr(sst_pkg::OFF_TX_CTRL, 32'h10);
        wr(sst_pkg::OFF_RX_CTRL, 32'h80);
        wr(sst_pkg::OFF_TX_CTRL, 32'h30);
        repeat (3) @(posedge aclk);
        chk({31'h0, data_oe}, 32'h1);
        $display("test modes done");
    endtask
    task automatic t_bytes();
        logic [8:0] w;
        wr(sst_pkg::OFF_TX_DATA, 32'hA5);
        repeat (3) @(posedge aclk);
        rdc(sst_pkg::OFF_TX_CTRL, 32'h02, 32'h00);
        lm_u.shift(8, 400, w);
        chk({23'h0, w}, 32'h0A5);
        poll(sst_pkg::OFF_TX_CTRL, 32'h02);
        wr(sst_pkg::OFF_TX_DATA, 32'h5C);
        lm_u.shift(8, 400, w);
        chk({23'h0, w}, 32'h05C);
        wr(sst_pkg::OFF_TX_CTRL, 32'h50);
        wr(sst_pkg::OFF_TX_CTRL, 32'h71);
        wr(sst_pkg::OFF_TX_DATA, 32'h3C);
        lm_u.shift(9, 400, w);
        chk({23'h0, w}, 32'h13C);
        poll(sst_pkg::OFF_TX_CTRL, 32'h02);
        wr(sst_pkg::OFF_TX_CTRL, 32'h30);
        $display("test bytes done");
    endtask
    task automatic t_sleep();
        logic [8:0] w;
        int wk;
        int vc;
        wr(sst_pkg::OFF_PERIPHERAL_IRQ_ENABLE_1, 32'h10);
        wr(sst_pkg::OFF_CORE_IRQ, 32'hC0);
        wr(sst_pkg::OFF_IRQ_MASK, 32'h01);
        wr(sst_pkg::OFF_TX_DATA, 32'h11);
        wr(sst_pkg::OFF_TX_DATA, 32'h22);
        wr(sst_pkg::OFF_IRQ_STAT, 32'h07);
        wr(sst_pkg::OFF_SLEEP, 32'h01);
        rdc(sst_pkg::OFF_PERIPHERAL_IRQ_FLAGS_1, 32'h10, 32'h00);
        chk({31'h0, irq}, 32'h0);
        wk = wake_cnt;
        vc = vec_cnt;
        lm_u.shift(8, 400, w);
        chk({23'h0, w}, 32'h011);
        poll(sst_pkg::OFF_PERIPHERAL_IRQ_FLAGS_1, 32'h10);
        repeat (2) @(posedge aclk);
        chk({31'h0, irq}, 32'h1);
        chk(32'(wake_cnt > wk), 32'h1);
        chk(32'(vec_cnt > vc), 32'h1);
        rdc(sst_pkg::OFF_SLEEP, 32'h01, 32'h00);
        wr(sst_pkg::OFF_IRQ_MASK, 32'h00);
        wr(sst_pkg::OFF_IRQ_STAT, 32'h07);
        repeat (2) @(posedge aclk);
        chk({31'h0, irq}, 32'h0);
        lm_u.shift(8, 400, w);
        chk({23'h0, w}, 32'h022);
        poll(sst_pkg::OFF_IRQ_STAT, 32'h02);
        chk({31'h0, irq}, 32'h0);
        $display("test sleep done");
    endtask
    task automatic complete_run();
        $display("compares %0d failures %0d", compares, failures);
        if (failures == 0 && compares > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    // Watchdog against a hung handshake
    initial begin
        #2000000;
        failures++;
        complete_run();
    end
    // Main sequence
    initial begin
        {aresetn, awvalid, wvalid, bready, arvalid, rready} = '0;
        {awaddr, araddr, wdata, v} = '0;
        wstrb = 4'hF;
        repeat (10) @(posedge aclk);
        aresetn <= 1'b1;
        t_regs();
        t_modes();
        t_bytes();
        t_sleep();
        complete_run();
    end
endmodule
